// [core/intc_defs.svh]
// Purpose: constants of the interrupt controller
// Assumes: included by its bare name
// Notes: offsets are register indices; byte address is index times four
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// =====================================================
// register indices
`define CENTRAL_CTRL_IDX 10'h0e6
`define EDGE_SEL_IDX 10'h0f2
`define EXT_PEND_IDX 10'h0f3
`define EXT_MASK_IDX 10'h0f4
`define EXT_PRIO_IDX 10'h0f5
`define TOP_VEC_IDX 10'h0f6
`define NEST_CTRL_IDX 10'h0f7

// =====================================================
// reset values
`define CENTRAL_CTRL_RST 8'h87
`define EXT_PRIO_RST 8'hff
`define LOWEST_LEVEL 3'h7

// =====================================================
// central control field positions
`define CC_RSVD_BIT 7
`define CC_PEND_BIT 6
`define CC_TMASK_BIT 5
`define CC_GIE_BIT 4
`define CC_MODE_BIT 3
`define CC_LVL_HI 2

// =====================================================
// top vector register and nested control fields
`define TV_EDGE_BIT 3
`define TV_SRC_BIT 2
`define NC_LOCK_BIT 7

// =====================================================
// timing in core clock cycles
`define ARB_LAST 3'h4
`define IMC_BASE 5'd18
`define IMC_RF_EXTRA 5'd2
`define IMC_SEG_EXTRA 5'd2
// arbitrary top-level vector value
`define TOP_VECTOR 8'h0c

`endif

// [core/intc_pkg.sv]
// Purpose: types of the interrupt controller
// Assumes: nothing
// Notes: states of the acknowledge sequencer
package intc_pkg;

   // =====================================================
   // acknowledge sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_ACK,
      S_WAKE,
      S_HOLD,
      S_IMC
   } ack_state_t;

endpackage

// [core/top_level_and_ext_interrupt_ctrl.sv]
// Purpose: top-level and external interrupt control with APB registers
// Assumes: pclk is the core clock; pins pass two flip-flops
// Notes: one wait state on every APB access
`timescale 1ns/1ps
`include "intc_defs.svh"

module top_level_and_ext_interrupt_ctrl
   import intc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt sources
   input wire logic nmi_pin,
   input wire logic [7:0] ext_int_pin,
   input wire logic wdg_end_count,
   // cpu sequencer
   input wire logic cpu_ei,
   input wire logic cpu_di,
   input wire logic cpu_iret,
   input wire logic cpu_write_done,
   input wire logic cpu_instr_end,
   input wire logic cpu_wfi,
   input wire logic stack_in_rf,
   input wire logic segment_push_enable,
   output logic int_abort,
   output logic int_service,
   output logic isr_start,
   output logic top_service,
   output logic [7:0] int_vector
);

   // =====================================================
   // state
   ack_state_t state_reg;
   logic [2:0] arb_cnt_reg;
   logic [4:0] imc_cnt_reg;
   logic win_top_reg;
   logic [2:0] win_idx_reg;
   logic [2:0] win_lvl_reg;
   logic [7:0] int_vector_reg;
   logic in_top_reg;
   logic top_pending_flag_reg;
   logic top_maskable_enable_reg;
   logic global_int_enable_reg;
   logic arbitration_mode_sel_reg;
   logic [2:0] current_priority_level_reg;
   logic [7:0] edge_sel_reg;
   logic [7:0] ext_pend_reg;
   logic [7:0] ext_mask_reg;
   logic [7:0] ext_prio_reg;
   logic [3:0] vec_hi_reg;
   logic top_edge_select_reg;
   logic top_source_select_reg;
   logic top_unmaskable_lock_reg;
   logic [6:0] hold_level_reg;
   logic nmi_s1_reg, nmi_s2_reg, nmi_d_reg;
   logic [7:0] ext_s1_reg, ext_s2_reg, ext_d_reg;
   logic pready_reg;
   logic [31:0] prdata_reg;

   logic [9:0] idx;
   logic acc, wr_en, rd_cap, mapped;
   logic [7:0] rd_val;
   logic nmi_evt, top_evt;
   logic [7:0] ext_evt, ch_req;
   logic top_req, arb_sample, grant;
   logic best_ok;
   logic [2:0] best_idx, best_lvl, lvl;
   logic imc_start, ack_now, ret_chan;
   logic [4:0] imc_len;
   logic [2:0] restore_lvl;
   logic [7:0] ack_mask;

   // =====================================================
   // apb decode, one wait state
   assign idx = paddr[11:2];
   assign acc = psel && penable;
   assign wr_en = acc && pwrite && pready_reg;
   assign rd_cap = acc && !pready_reg;
   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pready_reg && acc && !mapped;

   // read mux and map check
   always_comb begin
      mapped = 1'b1;
      rd_val = 8'h00;
      if (idx == `CENTRAL_CTRL_IDX) begin
         rd_val = {1'b1, top_pending_flag_reg, top_maskable_enable_reg,
                   global_int_enable_reg, arbitration_mode_sel_reg,
                   current_priority_level_reg};
      end else if (idx == `EDGE_SEL_IDX) begin
         rd_val = edge_sel_reg;
      end else if (idx == `EXT_PEND_IDX) begin
         rd_val = ext_pend_reg;
      end else if (idx == `EXT_MASK_IDX) begin
         rd_val = ext_mask_reg;
      end else if (idx == `EXT_PRIO_IDX) begin
         rd_val = ext_prio_reg;
      end else if (idx == `TOP_VEC_IDX) begin
         rd_val = {vec_hi_reg, top_edge_select_reg, top_source_select_reg,
                   2'b00};
      end else if (idx == `NEST_CTRL_IDX) begin
         rd_val = {top_unmaskable_lock_reg, hold_level_reg};
      end else begin
         mapped = 1'b0;
      end
   end

   // answer handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= rd_cap;
         if (rd_cap) begin
            prdata_reg <= {24'h00_0000, rd_val};
         end
      end
   end

   // =====================================================
   // pin synchronisers and edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_s1_reg <= 1'b0;
         nmi_s2_reg <= 1'b0;
         nmi_d_reg <= 1'b0;
         ext_s1_reg <= 8'h00;
         ext_s2_reg <= 8'h00;
         ext_d_reg <= 8'h00;
      end else begin
         nmi_s1_reg <= nmi_pin;
         nmi_s2_reg <= nmi_s1_reg;
         nmi_d_reg <= nmi_s2_reg;
         ext_s1_reg <= ext_int_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_d_reg <= ext_s2_reg;
      end
   end

   // selected top event and channel events
   assign nmi_evt = top_edge_select_reg ? (nmi_s2_reg && !nmi_d_reg)
                                        : (!nmi_s2_reg && nmi_d_reg);
   assign top_evt = top_source_select_reg ? nmi_evt : wdg_end_count;
   assign ext_evt = (edge_sel_reg & ext_s2_reg & ~ext_d_reg)
                  | (~edge_sel_reg & ~ext_s2_reg & ext_d_reg);

   // =====================================================
   // request qualification
   assign top_req = top_pending_flag_reg && (top_unmaskable_lock_reg
      || (top_maskable_enable_reg && global_int_enable_reg));
   assign ch_req = ext_pend_reg & ext_mask_reg
                 & {8{global_int_enable_reg}};

   // pick lowest-numbered level below current level
   always_comb begin
      best_ok = 1'b0;
      best_idx = 3'h0;
      best_lvl = `LOWEST_LEVEL;
      lvl = `LOWEST_LEVEL;
      for (int i = 0; i < 8; i++) begin
         lvl = {ext_prio_reg[(i / 2) * 2 + 1], ext_prio_reg[(i / 2) * 2],
                1'(i % 2)};
         if (ch_req[i] && (lvl < current_priority_level_reg)
             && (!best_ok || (lvl < best_lvl))) begin
            best_ok = 1'b1;
            best_idx = 3'(i);
            best_lvl = lvl;
         end
      end
   end

   // =====================================================
   // arbitration window counter, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arb_cnt_reg <= 3'h0;
      end else if (arb_cnt_reg == `ARB_LAST) begin
         arb_cnt_reg <= 3'h0;
      end else begin
         arb_cnt_reg <= arb_cnt_reg + 3'h1;
      end
   end

   assign arb_sample = arb_cnt_reg == `ARB_LAST;
   assign grant = arb_sample && (state_reg == S_IDLE) && !in_top_reg
                  && (top_req || best_ok);

   // =====================================================
   // acknowledge sequencer
   assign ack_now = state_reg == S_ACK;
   assign imc_start = (state_reg == S_HOLD)
                      && (!cpu_write_done || cpu_instr_end);
   assign int_abort = (state_reg == S_HOLD) && !cpu_write_done;
   assign int_service = state_reg == S_IMC;
   assign isr_start = int_service && (imc_cnt_reg == 5'd0);
   assign top_service = in_top_reg;
   assign int_vector = int_vector_reg;
   assign imc_len = `IMC_BASE
                    + (stack_in_rf ? `IMC_RF_EXTRA : 5'd0)
                    + (segment_push_enable ? `IMC_SEG_EXTRA : 5'd0);

   // state transitions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (grant) begin
                  state_reg <= S_ACK;
               end
            end
            S_ACK: begin
               state_reg <= cpu_wfi ? S_WAKE : S_HOLD;
            end
            S_WAKE: begin
               state_reg <= S_HOLD;
            end
            S_HOLD: begin
               if (imc_start) begin
                  state_reg <= S_IMC;
               end
            end
            S_IMC: begin
               if (imc_cnt_reg == 5'd0) begin
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // machine cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imc_cnt_reg <= 5'd0;
      end else if (imc_start) begin
         imc_cnt_reg <= imc_len - 5'd1;
      end else if (int_service && (imc_cnt_reg != 5'd0)) begin
         imc_cnt_reg <= imc_cnt_reg - 5'd1;
      end
   end

   // winner latch and vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_top_reg <= 1'b0;
         win_idx_reg <= 3'h0;
         win_lvl_reg <= `LOWEST_LEVEL;
         int_vector_reg <= 8'h00;
      end else if (grant) begin
         win_top_reg <= top_req;
         win_idx_reg <= best_idx;
         win_lvl_reg <= best_lvl;
         int_vector_reg <= top_req ? `TOP_VECTOR
                           : {vec_hi_reg, best_idx, 1'b0};
      end
   end

   // top routine in service
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_top_reg <= 1'b0;
      end else if (imc_start && win_top_reg) begin
         in_top_reg <= 1'b1;
      end else if (cpu_iret) begin
         in_top_reg <= 1'b0;
      end
   end

   // =====================================================
   // pending flags, set wins over clear
   assign ack_mask = (ack_now && !win_top_reg) ? (8'h01 << win_idx_reg)
                                                : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_pending_flag_reg <= 1'b0;
      end else if (top_evt || (wr_en && (idx == `CENTRAL_CTRL_IDX)
                               && pwdata[`CC_PEND_BIT])) begin
         top_pending_flag_reg <= 1'b1;
      end else if (ack_now && win_top_reg) begin
         top_pending_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_pend_reg <= 8'h00;
      end else if (wr_en && (idx == `EXT_PEND_IDX)) begin
         ext_pend_reg <= pwdata[7:0] | ext_evt;
      end else begin
         ext_pend_reg <= (ext_pend_reg & ~ack_mask) | ext_evt;
      end
   end

   // =====================================================
   // global enable
   assign ret_chan = cpu_iret && !in_top_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_int_enable_reg <= 1'b0;
      end else if (wr_en && (idx == `CENTRAL_CTRL_IDX)) begin
         global_int_enable_reg <= pwdata[`CC_GIE_BIT];
      end else if (cpu_di) begin
         global_int_enable_reg <= 1'b0;
      end else if (cpu_ei) begin
         global_int_enable_reg <= 1'b1;
      end else if (imc_start && !win_top_reg) begin
         global_int_enable_reg <= 1'b0;
      end else if (ret_chan) begin
         global_int_enable_reg <= 1'b1;
      end
   end

   // =====================================================
   // nested level save and restore
   always_comb begin
      restore_lvl = `LOWEST_LEVEL;
      for (int i = 6; i >= 0; i--) begin
         if (hold_level_reg[i]) begin
            restore_lvl = 3'(i);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_priority_level_reg <= `LOWEST_LEVEL;
         hold_level_reg <= 7'h00;
      end else if (wr_en && (idx == `CENTRAL_CTRL_IDX)) begin
         current_priority_level_reg <= pwdata[`CC_LVL_HI:0];
      end else if (imc_start && !win_top_reg && arbitration_mode_sel_reg) begin
         current_priority_level_reg <= win_lvl_reg;
         if (current_priority_level_reg != `LOWEST_LEVEL) begin
            hold_level_reg[current_priority_level_reg] <= 1'b1;
         end
      end else if (ret_chan && arbitration_mode_sel_reg) begin
         current_priority_level_reg <= restore_lvl;
         if (restore_lvl != `LOWEST_LEVEL) begin
            hold_level_reg[restore_lvl] <= 1'b0;
         end
      end
   end

   // =====================================================
   // plain software fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_maskable_enable_reg <= 1'b0;
         arbitration_mode_sel_reg <= 1'b0;
         edge_sel_reg <= 8'h00;
         ext_mask_reg <= 8'h00;
         ext_prio_reg <= `EXT_PRIO_RST;
         vec_hi_reg <= 4'h0;
         top_edge_select_reg <= 1'b0;
         top_source_select_reg <= 1'b1;
      end else if (wr_en) begin
         if (idx == `CENTRAL_CTRL_IDX) begin
            top_maskable_enable_reg <= pwdata[`CC_TMASK_BIT];
            arbitration_mode_sel_reg <= pwdata[`CC_MODE_BIT];
         end else if (idx == `EDGE_SEL_IDX) begin
            edge_sel_reg <= pwdata[7:0];
         end else if (idx == `EXT_MASK_IDX) begin
            ext_mask_reg <= pwdata[7:0];
         end else if (idx == `EXT_PRIO_IDX) begin
            ext_prio_reg <= pwdata[7:0];
         end else if (idx == `TOP_VEC_IDX) begin
            vec_hi_reg <= pwdata[7:4];
            top_edge_select_reg <= pwdata[`TV_EDGE_BIT];
            top_source_select_reg <= pwdata[`TV_SRC_BIT];
         end
      end
   end

   // set-only lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_unmaskable_lock_reg <= 1'b0;
      end else if (wr_en && (idx == `NEST_CTRL_IDX) && pwdata[`NC_LOCK_BIT]) begin
         top_unmaskable_lock_reg <= 1'b1;
      end
   end

   // =====================================================
   // assertions
   a_pin_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (top_source_select_reg && top_edge_select_reg && nmi_s2_reg && !nmi_d_reg)
      |=> top_pending_flag_reg) else $error("rising pin edge lost");
   a_wdg_source: assert property (@(posedge pclk) disable iff (!presetn)
      (!top_source_select_reg && wdg_end_count) |=> top_pending_flag_reg)
      else $error("watchdog end of count lost");
   a_top_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (ack_now && win_top_reg && !top_evt && !wr_en) |=> !top_pending_flag_reg)
      else $error("top pending not cleared");
   a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      top_unmaskable_lock_reg |=> top_unmaskable_lock_reg)
      else $error("lock cleared");
   a_top_blocks_all: assert property (@(posedge pclk) disable iff (!presetn)
      (in_top_reg && state_reg == S_IDLE && !cpu_iret) |=> state_reg == S_IDLE)
      else $error("granted during top routine");
   a_top_keeps_enable: assert property (@(posedge pclk) disable iff (!presetn)
      (imc_start && win_top_reg && !cpu_ei && !cpu_di && !cpu_iret && !wr_en)
      |=> global_int_enable_reg == $past(global_int_enable_reg))
      else $error("top cycle changed enable");
   a_chan_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (grant && !top_req) |-> (ext_mask_reg[best_idx] && global_int_enable_reg))
      else $error("masked channel granted");
   a_level_below: assert property (@(posedge pclk) disable iff (!presetn)
      (grant && !top_req) |-> best_lvl < current_priority_level_reg)
      else $error("level not below current");
   a_ack_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      grant |=> ack_now ##1 (state_reg == ($past(cpu_wfi) ? S_WAKE : S_HOLD)))
      else $error("acknowledge cycle wrong");
   a_imc_length: assert property (@(posedge pclk) disable iff (!presetn)
      (imc_start && !stack_in_rf && !segment_push_enable)
      |=> (int_service && imc_cnt_reg == 5'd17) ##17 isr_start ##1 !int_service)
      else $error("machine cycle length");
   a_chan_clears_enable: assert property (@(posedge pclk) disable iff (!presetn)
      (imc_start && !win_top_reg && !cpu_ei && !wr_en) |=> !global_int_enable_reg)
      else $error("enable not cleared");
   a_ext_edge_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (ext_evt != 8'h00) |=> (ext_pend_reg & $past(ext_evt)) == $past(ext_evt))
      else $error("external edge lost");
   c_top_grant: cover property (@(posedge pclk) imc_start && win_top_reg);
   c_chan_abort: cover property (@(posedge pclk) int_abort && !win_top_reg);
   c_nested_save: cover property (@(posedge pclk) imc_start && arbitration_mode_sel_reg
      && current_priority_level_reg != `LOWEST_LEVEL);

endmodule

// [dv/cpu_seq_model.sv]
// Purpose: stand-in for the core sequencer
// Assumes: every instruction takes five core cycles
// Notes: knob writes marks every instruction as already written
`timescale 1ns/1ps
module cpu_seq_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // knob
   input wire logic writes,
   // sequencer side
   output logic cpu_write_done,
   output logic cpu_instr_end
);
   logic [2:0] step_reg;
   // =========================================
   // instruction step counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_reg <= 3'h0;
      end else begin
         step_reg <= (step_reg == 3'h4) ? 3'h0 : step_reg + 3'h1;
      end
   end
   // with the knob set the instruction has written: no abort
   assign cpu_write_done = writes;
   assign cpu_instr_end = (step_reg == 3'h4);
endmodule

// [dv/top_level_and_ext_interrupt_ctrl_tb.sv]
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait state on apb, free running arbitration
// Notes: random channel, stack and abort settings with fixed seed
`timescale 1ns/1ps
`include "intc_defs.svh"
module top_level_and_ext_interrupt_ctrl_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic nmi_pin = 0, wdg_end_count = 0, cpu_ei = 0, cpu_di = 0, cpu_iret = 0;
   logic cpu_wfi = 0, stack_in_rf = 0, segment_push_enable = 0, writes = 0;
   logic cpu_write_done, cpu_instr_end, pready, pslverr, int_abort;
   logic int_service, isr_start, top_service, er, ab, seen;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [7:0] ext_int_pin = 8'h00, int_vector, rd, e;
   int err_total = 0, compares = 0, svc, ch;
   // =========================================
   // clock, design and sequencer
   always #2 pclk = ~pclk;
   top_level_and_ext_interrupt_ctrl DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmi_pin(nmi_pin), .ext_int_pin(ext_int_pin), .wdg_end_count(wdg_end_count),
      .cpu_ei(cpu_ei), .cpu_di(cpu_di), .cpu_iret(cpu_iret),
      .cpu_write_done(cpu_write_done), .cpu_instr_end(cpu_instr_end),
      .cpu_wfi(cpu_wfi), .stack_in_rf(stack_in_rf),
      .segment_push_enable(segment_push_enable), .int_abort(int_abort),
      .int_service(int_service), .isr_start(isr_start),
      .top_service(top_service), .int_vector(int_vector));
   cpu_seq_model partner (.pclk(pclk), .presetn(presetn), .writes(writes),
      .cpu_write_done(cpu_write_done), .cpu_instr_end(cpu_instr_end));
   // =========================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
         err_total++;
         end_sim();
      end
   endtask
   // k 0 enable, 1 disable, 2 return
   task automatic cpu_pulse(input int k);
      @(posedge pclk);
      cpu_ei <= (k == 0);
      cpu_di <= (k == 1);
      cpu_iret <= (k == 2);
      @(posedge pclk);
      cpu_ei <= 0;
      cpu_di <= 0;
      cpu_iret <= 0;
   endtask
   task automatic quiet(input int n);
      seen = 0;
      repeat (n) begin
         @(posedge pclk);
         if (int_service !== 1'b0) seen = 1;
      end
   endtask
   task automatic wait_isr();
      int n;
      n = 0;
      svc = 0;
      ab = 0;
      do begin
         @(posedge pclk);
         n++;
         if (int_service === 1'b1) svc++;
         if (int_abort === 1'b1) ab = 1;
      end while (isr_start !== 1'b1 && n < 300);
      if (n >= 300) begin
         err_total++;
         end_sim();
      end
   endtask
   // =========================================
   // hang guard
   initial begin
      repeat (60000) @(posedge pclk);
      err_total++;
      end_sim();
   end
   // =========================================
   // main sequence
   initial begin
      void'($urandom(32'ha1437ffb));
      repeat (4) @(posedge pclk);
      presetn <= 1;
      apb(0, `CENTRAL_CTRL_IDX, 0);
      chk(rd, 8'h87, "central reset");
      apb(0, `EXT_PEND_IDX, 0);
      chk(rd, 8'h00, "pending reset");
      apb(0, 10'h3ff, 0);
      chk({rd, er}, 9'h001, "unmapped read");
      // edge select, both directions per pin
      for (int i = 0; i < 4; i++) begin
         e = $urandom;
         apb(1, `EDGE_SEL_IDX, e);
         ext_int_pin <= ~e;
         repeat (6) @(posedge pclk);
         apb(1, `EXT_PEND_IDX, 8'h00);
         ext_int_pin <= e;
         repeat (6) @(posedge pclk);
         apb(0, `EXT_PEND_IDX, 0);
         chk(rd, 8'hff, "chosen edges");
         apb(1, `EXT_PEND_IDX, 8'h00);
         ext_int_pin <= ~e;
         repeat (6) @(posedge pclk);
         apb(0, `EXT_PEND_IDX, 0);
         chk(rd, 8'h00, "opposite edges");
      end
      // software raised channel requests
      apb(1, `EXT_MASK_IDX, 8'hff);
      for (int i = 0; i < 6; i++) begin
         ch = 2 * ($urandom % 4);
         writes <= $urandom;
         cpu_wfi <= $urandom;
         stack_in_rf <= $urandom;
         segment_push_enable <= $urandom;
         apb(1, `EXT_PEND_IDX, 8'h01 << ch);
         cpu_pulse(0);
         wait_isr();
         chk(svc, 18 + 2 * stack_in_rf + 2 * segment_push_enable, "cycle");
         chk(int_vector, {4'h0, ch[2:0], 1'b0}, "vector");
         chk(ab, !writes, "abort choice");
         apb(0, `EXT_PEND_IDX, 0);
         chk(rd, 8'h00, "ack clears");
         apb(0, `CENTRAL_CTRL_IDX, 0);
         chk(rd[4], 0, "cycle clears enable");
         cpu_pulse(2);
         apb(0, `CENTRAL_CTRL_IDX, 0);
         chk(rd[4], 1, "return sets enable");
         cpu_pulse(1);
      end
      // nested mode saves and restores the level
      apb(1, `CENTRAL_CTRL_IDX, 8'h8f);
      apb(1, `EXT_PEND_IDX, 8'h01);
      cpu_pulse(0);
      wait_isr();
      apb(1, `EXT_PRIO_IDX, 8'hf3);
      apb(1, `EXT_PEND_IDX, 8'h04);
      cpu_pulse(0);
      wait_isr();
      apb(0, `NEST_CTRL_IDX, 0);
      chk(rd, 8'h40, "level saved");
      cpu_pulse(2);
      apb(0, `CENTRAL_CTRL_IDX, 0);
      chk(rd, 8'h9e, "level restored");
      cpu_pulse(2);
      apb(0, `CENTRAL_CTRL_IDX, 0);
      chk(rd, 8'h9f, "level back to lowest");
      apb(1, `CENTRAL_CTRL_IDX, 8'h87);
      // masked channel and lowest level stay silent
      apb(1, `EXT_MASK_IDX, 8'h02);
      apb(1, `EXT_PEND_IDX, 8'h03);
      cpu_pulse(0);
      quiet(20);
      chk(seen, 0, "masked or lowest");
      cpu_pulse(1);
      apb(1, `EXT_PEND_IDX, 8'h00);
      // maskable top level
      apb(1, `EXT_MASK_IDX, 8'h01);
      apb(1, `CENTRAL_CTRL_IDX, 8'hc7);
      quiet(20);
      chk(seen, 0, "top without enable");
      apb(1, `CENTRAL_CTRL_IDX, 8'he7);
      cpu_pulse(0);
      wait_isr();
      chk({top_service, int_vector}, {1'b1, `TOP_VECTOR}, "top grant");
      apb(0, `CENTRAL_CTRL_IDX, 0);
      chk(rd[6:4], 3'b011, "top ack");
      apb(1, `EXT_PEND_IDX, 8'h01);
      quiet(20);
      chk(seen, 0, "blocked in top");
      cpu_pulse(2);
      wait_isr();
      chk(int_vector, 8'h00, "after top return");
      cpu_pulse(2);
      cpu_pulse(1);
      // unmaskable lock with watchdog source
      apb(1, `NEST_CTRL_IDX, 8'h80);
      apb(1, `NEST_CTRL_IDX, 8'h00);
      apb(0, `NEST_CTRL_IDX, 0);
      chk(rd[7], 1, "lock sticks");
      apb(1, `TOP_VEC_IDX, 8'h00);
      wdg_end_count <= 1;
      @(posedge pclk);
      wdg_end_count <= 0;
      wait_isr();
      chk(top_service, 1, "watchdog top");
      cpu_pulse(2);
      apb(0, `CENTRAL_CTRL_IDX, 0);
      chk(rd[4], 0, "top return");
      // pin source, rising then falling
      for (int k = 1; k >= 0; k--) begin
         apb(1, `TOP_VEC_IDX, k ? 8'h0c : 8'h04);
         nmi_pin <= k;
         wait_isr();
         chk(top_service, 1, "pin edge");
         cpu_pulse(2);
      end
      end_sim();
   end
endmodule
